//--- verilog/lcd_serial_command_decoder.sv
/*
 * serial link decoder: mode ids, display ram access and command words.
 * assumes cs_n, wr_n, rd_n and data arrive asynchronously from a host mcu;
 * each passes two flip-flops before use. strobes must be slower than 4 clocks.
 */
// How it works
// - id 110, six address bits msb first, then nibbles returned lsb first
// - id 101, address msb first, nibble d0 first stored in ram
// - after 101 address, stored nibble shifts out on read strobes, then replaced
// - id 100 once; further nine-bit commands follow without id while selected
// - nine bits per command; 0000-0000 stops oscillator and bias, reset default
// - 0000-0001 starts the oscillator
// - 0000-0010 bias off (default), 0000-0011 bias on
// - 0000-0100 time base output off, 0000-0110 on
// - 0000-0101 watchdog flag output off, 0000-0111 on
// - 0000-1000 buzzer off, 0000-1001 buzzer on
// - 0000-11xx clears the time base count
// - 0000-111x clears watchdog stage, and time base too
// - clock source crystal, internal rc (default) or external
// - 0010-abxc sets bias by c and commons by ab
// - 010x selects high pitch, 011x low pitch, divided from system clock
// - 101x-xnnn sets time base rate 2^nnn hz, default 128 hz
// - same rate code sets watchdog timeout, 4s down to 1/32s
// - 1110-0000 test mode, 1110-0011 normal mode (default)
// - data line sampled on each write strobe rising edge
// - ram data bits driven on read strobe falling edge
// - select high aborts transfer and clears mode; new id needed
// - with external clock selected, system disable is ignored
module lcd_serial_command_decoder
    import lcd_cmd_pkg::*;
#(
    parameter int RAM_WORDS = 32
)(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_cs_n,
    input wire logic i_wr_n,
    input wire logic i_rd_n,
    input wire logic i_data,
    output logic o_data,
    output logic o_data_oe,
    output logic o_oscillator_on,
    output logic o_bias_gen_on,
    output logic o_timebase_out_on,
    output logic o_watchdog_flag_on,
    output logic o_buzzer_drive_on,
    output logic o_timebase_clear,
    output logic o_watchdog_clear,
    output logic [1:0] o_clock_source,
    output logic o_bias_third,
    output logic [1:0] o_commons,
    output logic o_buzzer_low_pitch,
    output logic o_flag_pin_on,
    output logic [2:0] o_rate_code,
    output logic o_test_mode,
    output logic [3:0] o_ram_nibble_dbg
);
    // pin synchronisers
    logic [3:0] s1_q, s2_q, s3_q;
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            s1_q <= 4'h0_00f;
            s2_q <= 4'h0_00f;
            s3_q <= 4'h0_00f;
        end
        else
        begin
            s1_q <= {i_cs_n, i_wr_n, i_rd_n, i_data};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    logic cs_n, din, wr_rise, rd_fall;
    assign cs_n = s2_q[3];
    assign din = s2_q[0];
    assign wr_rise = s2_q[2] & ~s3_q[2] & ~cs_n;
    assign rd_fall = ~s2_q[1] & s3_q[1] & ~cs_n;

    logic [3:0] ram_q [RAM_WORDS];
    link_state_e st_q, st_d;
    logic [8:0] sh_q, sh_d;
    logic [3:0] cnt_q, cnt_d;
    logic [5:0] addr_q, addr_d;
    logic is_read_q, is_read_d;
    logic rmw_q, rmw_d;
    logic [3:0] rbuf_q, rbuf_d;
    logic [1:0] rpos_q, rpos_d;
    logic dout_q, dout_d, oe_q, oe_d;
    logic wen;
    logic [3:0] wnib;
    logic cmd_go;
    logic [8:0] cmd_w;

    always_comb
    begin
        st_d = st_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        is_read_d = is_read_q;
        rmw_d = rmw_q;
        rbuf_d = rbuf_q;
        rpos_d = rpos_q;
        dout_d = dout_q;
        oe_d = oe_q;
        wen = 1'b0;
        wnib = {din, sh_q[8:6]};
        cmd_go = 1'b0;
        cmd_w = {sh_q[7:0], din};
        if (cs_n)
        begin
            st_d = ST_ID;
            cnt_d = 4'h0_000;
            oe_d = 1'b0;
            rmw_d = 1'b0;
            rpos_d = 2'h0_000;
        end
        else
        begin
            if (wr_rise)
            begin
                sh_d = {sh_q[7:0], din};
                cnt_d = cnt_q + 4'h0_001;
                case (st_q)
                    ST_ID:
                        if (cnt_q == 4'(ID_BITS - 1))
                        begin
                            cnt_d = 4'h0_000;
                            is_read_d = ({sh_q[1:0], din} == ID_READ);
                            if ({sh_q[1:0], din} == ID_COMMAND)
                                st_d = ST_CMD;
                            else if ({sh_q[1:0], din} == ID_READ ||
                                     {sh_q[1:0], din} == ID_WRITE)
                                st_d = ST_ADDR;
                        end
                    ST_ADDR:
                        if (cnt_q == 4'(ADDR_BITS - 1))
                        begin
                            cnt_d = 4'h0_000;
                            addr_d = {sh_q[4:0], din};
                            st_d = is_read_q ? ST_RDATA : ST_WDATA;
                        end
                    ST_WDATA:
                    begin
                        sh_d = {din, sh_q[8:1]}; // lsb first
                        if (cnt_q == 4'(NIBBLE_BITS - 1))
                        begin
                            cnt_d = 4'h0_000;
                            wen = 1'b1;
                            addr_d = addr_q + 6'h0_001;
                            rmw_d = 1'b0;
                            rpos_d = 2'h0_000;
                        end
                    end
                    ST_CMD:
                        if (cnt_q == 4'(CMD_BITS - 1))
                        begin
                            cnt_d = 4'h0_000;
                            cmd_go = 1'b1;
                        end
                    default: st_d = ST_ID;
                endcase
            end
            if (rd_fall && (st_q == ST_RDATA || st_q == ST_WDATA))
            begin
                // read, or modify phase of 101 access
                if (rpos_q == 2'h0_000 && !rmw_q)
                begin
                    rbuf_d = ram_q[5'(addr_q)];
                    dout_d = ram_q[5'(addr_q)][0];
                end
                else
                    dout_d = rbuf_q[rpos_q];
                oe_d = 1'b1;
                rmw_d = (st_q == ST_WDATA);
                rpos_d = rpos_q + 2'h0_001;
                if (rpos_q == 2'h0_003 && st_q == ST_RDATA)
                    addr_d = addr_q + 6'h0_001;
            end
            if (!s2_q[2])
                oe_d = 1'b0; // line freed before host bit is taken
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            st_q <= ST_ID;
            sh_q <= '0;
            cnt_q <= '0;
            addr_q <= '0;
            is_read_q <= 1'b0;
            rmw_q <= 1'b0;
            rbuf_q <= '0;
            rpos_q <= '0;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            is_read_q <= is_read_d;
            rmw_q <= rmw_d;
            rbuf_q <= rbuf_d;
            rpos_q <= rpos_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (wen)
            ram_q[5'(addr_q)] <= wnib;
    end

    // command decoder state
    logic osc_q, osc_d, bias_q, bias_d, tb_q, tb_d, wd_q, wd_d, bz_q, bz_d;
    logic tclr_q, tclr_d, wclr_q, wclr_d, third_q, third_d, low_q, low_d;
    logic flag_q, flag_d, test_q, test_d;
    logic [1:0] src_q, src_d, com_q, com_d;
    logic [2:0] rate_q, rate_d;
    always_comb
    begin
        osc_d = osc_q;
        bias_d = bias_q;
        tb_d = tb_q;
        wd_d = wd_q;
        bz_d = bz_q;
        tclr_d = 1'b0;
        wclr_d = 1'b0;
        third_d = third_q;
        low_d = low_q;
        flag_d = flag_q;
        test_d = test_q;
        src_d = src_q;
        com_d = com_q;
        rate_d = rate_q;
        if (cmd_go)
        begin
            case (cmd_w[8:6])
                3'b000:
                    if (cmd_w[8:5] == 4'h0_000)
                    begin
                        case (cmd_w[4:1])
                            4'h0_000:
                                if (src_q != SRC_EXTERNAL)
                                begin
                                    osc_d = 1'b0;
                                    bias_d = 1'b0;
                                end
                            4'h0_001: osc_d = 1'b1;
                            4'h0_002: bias_d = 1'b0;
                            4'h0_003: bias_d = 1'b1;
                            4'h0_004: tb_d = 1'b0;
                            4'h0_006: tb_d = 1'b1;
                            4'h0_005: wd_d = 1'b0;
                            4'h0_007: wd_d = 1'b1;
                            4'h0_008: bz_d = 1'b0;
                            4'h0_009: bz_d = 1'b1;
                            default:
                            begin
                                tclr_d = (cmd_w[4:3] == 2'b11);
                                wclr_d = (cmd_w[4:2] == 3'b111);
                            end
                        endcase
                    end
                    else if (cmd_w[4:3] != 2'b00)
                        src_d = cmd_w[4:3];
                3'b001:
                    if (cmd_w[5] == 1'b0)
                    begin
                        com_d = cmd_w[4:3];
                        third_d = cmd_w[1];
                    end
                3'b010: low_d = 1'b0;
                3'b011: low_d = 1'b1;
                3'b100: flag_d = cmd_w[4];
                3'b101: rate_d = cmd_w[3:1];
                3'b111:
                    if (cmd_w[8:1] == CMD_TEST)
                        test_d = 1'b1;
                    else if (cmd_w[8:1] == CMD_NORMAL)
                        test_d = 1'b0;
                default: ;
            endcase
        end
    end

    // power-on defaults; host reinitialises anyway
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            osc_q <= 1'b0;
            bias_q <= 1'b0;
            tb_q <= 1'b0;
            wd_q <= 1'b0;
            bz_q <= 1'b0;
            tclr_q <= 1'b0;
            wclr_q <= 1'b0;
            third_q <= 1'b0;
            low_q <= 1'b0;
            flag_q <= 1'b0;
            test_q <= 1'b0;
            src_q <= SRC_RESET;
            com_q <= COMMONS_RESET;
            rate_q <= RATE_RESET;
        end
        else
        begin
            osc_q <= osc_d;
            bias_q <= bias_d;
            tb_q <= tb_d;
            wd_q <= wd_d;
            bz_q <= bz_d;
            tclr_q <= tclr_d;
            wclr_q <= wclr_d;
            third_q <= third_d;
            low_q <= low_d;
            flag_q <= flag_d;
            test_q <= test_d;
            src_q <= src_d;
            com_q <= com_d;
            rate_q <= rate_d;
        end
    end

    assign o_data = dout_q;
    assign o_data_oe = oe_q;
    assign o_oscillator_on = osc_q;
    assign o_bias_gen_on = bias_q;
    assign o_timebase_out_on = tb_q;
    assign o_watchdog_flag_on = wd_q;
    assign o_buzzer_drive_on = bz_q;
    assign o_timebase_clear = tclr_q;
    assign o_watchdog_clear = wclr_q;
    assign o_clock_source = src_q;
    assign o_bias_third = third_q;
    assign o_commons = com_q;
    assign o_buzzer_low_pitch = low_q;
    assign o_flag_pin_on = flag_q;
    assign o_rate_code = rate_q;
    assign o_test_mode = test_q;
    assign o_ram_nibble_dbg = rbuf_q;
endmodule

//--- verilog/lcd_cmd_pkg.sv
/*
 * constants for the serial command decoder of a 32x4 segment display driver.
 * assumes a single 100 MHz clock domain.
 */
package lcd_cmd_pkg;
    localparam logic [2:0] ID_READ = 3'b110;
    localparam logic [2:0] ID_WRITE = 3'b101;
    localparam logic [2:0] ID_COMMAND = 3'b100;
    localparam int ID_BITS = 3;
    localparam int ADDR_BITS = 6;
    localparam int NIBBLE_BITS = 4;
    localparam int CMD_BITS = 9;
    localparam logic [1:0] SRC_CRYSTAL = 2'b01;
    localparam logic [1:0] SRC_INTERNAL = 2'b10;
    localparam logic [1:0] SRC_EXTERNAL = 2'b11;
    localparam logic [2:0] RATE_RESET = 3'b111;
    localparam logic [1:0] COMMONS_RESET = 2'b10;
    localparam logic [1:0] SRC_RESET = 2'b10;
    localparam logic [7:0] CMD_TEST = 8'h0_0e0;
    localparam logic [7:0] CMD_NORMAL = 8'h0_0e3;
    typedef enum logic [2:0] {ST_ID, ST_ADDR, ST_WDATA, ST_RDATA, ST_CMD} link_state_e;
endpackage

//--- test/lcd_serial_command_decoder_chk.sv
/* port checker for the serial command decoder.
   assumes it is bound to the decoder and sees one clock domain. */
module lcd_serial_command_decoder_chk
    import lcd_cmd_pkg::*;
#(
    parameter int RAM_WORDS = 32
)(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_cs_n,
    input wire logic i_wr_n,
    input wire logic i_rd_n,
    input wire logic o_data_oe,
    input wire logic o_oscillator_on,
    input wire logic o_bias_gen_on,
    input wire logic o_timebase_clear,
    input wire logic o_watchdog_clear,
    input wire logic [1:0] o_clock_source,
    input wire logic [2:0] o_rate_code
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    logic [3:0] idle_q;
    logic [3:0] idle_d;
    // cycles since the write strobe was last low
    always_comb
    begin
        idle_d = (idle_q == 4'hf) ? idle_q : idle_q + 4'h1;
        if (i_srst || !i_wr_n)
        begin
            idle_d = 4'h0;
        end
    end
    always_ff @(posedge i_clk)
    begin
        idle_q <= idle_d;
    end
    a_clear_one_cycle: assert property (o_timebase_clear |=> !o_timebase_clear)
        else $error("time base clear longer than one cycle");
    a_wdt_clear_both: assert property (o_watchdog_clear |-> o_timebase_clear)
        else $error("watchdog clear without time base clear");
    a_quiet_no_change: assert property ((idle_q > 4'h6) |-> $stable(o_rate_code)
        && $stable(o_clock_source) && !o_timebase_clear)
        else $error("command effect without write strobe");
    a_ext_keeps_osc: assert property
        ((o_clock_source == SRC_EXTERNAL) && o_oscillator_on |=> o_oscillator_on)
        else $error("oscillator stopped on external clock");
    a_sysdis_both_off: assert property ($fell(o_oscillator_on) |-> !o_bias_gen_on)
        else $error("bias left on after system disable");
    a_deselect_no_drive: assert property (i_cs_n [*6] |-> !o_data_oe)
        else $error("data driven while deselected");
    a_drive_on_read: assert property ($rose(o_data_oe) |-> !i_rd_n)
        else $error("data driven without read strobe");
    a_write_drops_oe: assert property
        (!i_cs_n && $rose(i_wr_n) |-> ##[1:6] !o_data_oe)
        else $error("data still driven during write");
endmodule

bind lcd_serial_command_decoder lcd_serial_command_decoder_chk #(.RAM_WORDS(RAM_WORDS)) chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_cs_n(i_cs_n), .i_wr_n(i_wr_n), .i_rd_n(i_rd_n),
    .o_data_oe(o_data_oe), .o_oscillator_on(o_oscillator_on), .o_bias_gen_on(o_bias_gen_on),
    .o_timebase_clear(o_timebase_clear), .o_watchdog_clear(o_watchdog_clear),
    .o_clock_source(o_clock_source), .o_rate_code(o_rate_code));

//--- test/lcd_host_model.sv
/* host controller model: select, strobes and data line.
   assumes the device splits its data pin into value and enable. */
module lcd_host_model (
    input wire logic i_clk,
    input wire logic i_dev_data,
    input wire logic i_dev_oe,
    output logic o_cs_n,
    output logic o_wr_n,
    output logic o_rd_n,
    output logic o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'b1;
    logic bit_q = 1'b1;
    initial
    begin
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        o_rd_n = 1'b1;
    end
    // released line shows the inverse of the last bit
    assign o_data = i_dev_oe ? i_dev_data : (drv ? bit_q : ~bit_q);
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic sel(input logic s);
        tick(1);
        o_cs_n <= s;
        tick(6);
    endtask
    task automatic put(input logic b);
        @(posedge i_clk);
        drv <= 1'b1;
        bit_q <= b;
        o_wr_n <= 1'b0;
        tick(6);
        o_wr_n <= 1'b1;
        tick(6);
    endtask
    task automatic get(output logic b);
        @(posedge i_clk);
        drv <= 1'b0;
        o_rd_n <= 1'b0;
        tick(6);
        o_rd_n <= 1'b1;
        tick(4);
        b = o_data;
    endtask
    task automatic id(input logic [2:0] v);
        for (int i = 2; i >= 0; i--) put(v[i]);
    endtask
    task automatic addr(input logic [5:0] v);
        for (int i = 5; i >= 0; i--) put(v[i]);
    endtask
    task automatic cmd(input logic [8:0] v);
        for (int i = 8; i >= 0; i--) put(v[i]);
    endtask
    task automatic nib(input logic [3:0] v);
        for (int i = 0; i < 4; i++) put(v[i]);
    endtask
    task automatic rnib(output logic [3:0] v);
        for (int i = 0; i < 4; i++) get(v[i]);
    endtask
endmodule

//--- test/tb_top.sv
/* self-checking bench for the serial command decoder.
   assumes the host model drives the link and the checker is bound. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cs_n, wr_n, rd_n, din, dout, doe, tbc, wdc, osc, bias, tbo, wdf, buzz;
    logic third, low, flag, tst;
    logic [1:0] src, com;
    logic [2:0] rate;
    logic [3:0] n;
    logic [3:0] dbg;
    logic [7:0] ntb = 8'h00;
    logic [7:0] nwd = 8'h00;
    logic [15:0] st;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    // command code, then expected outputs
    logic [23:0] rows [23] = '{24'h01_848e, 24'h03_c48e, 24'h06_e48e, 24'h07_f48e,
        24'h09_fc8e, 24'h14_fa8e, 24'h1c_fe8e, 24'h00_fe8e, 24'h18_fc8e, 24'h25_fd4e,
        24'h60_fd6e, 24'h40_fd4e, 24'h88_fd5e, 24'ha0_fd50, 24'ha5_fd5a, 24'he0_fd5b,
        24'he3_fd5a, 24'h80_fd4a, 24'h08_f54a, 24'h05_e54a, 24'h04_c54a, 24'h02_854a,
        24'h00_054a};
    // link steps: op nibble, then value
    logic [19:0] link [39] = '{20'h0_0000, 20'h1_0004, 20'h3_0018, 20'h3_001c, 20'h7_0201,
        20'h0_0001, 20'h0_0000, 20'h1_0004, 20'h2_0000, 20'h0_0001, 20'h0_0000, 20'h3_0006,
        20'h0_0001, 20'h6_048e, 20'h0_0000, 20'h1_0005, 20'h2_003f, 20'h4_0005, 20'h4_000c,
        20'h0_0001, 20'h0_0000, 20'h1_0006, 20'h2_003f, 20'h5_0005, 20'h5_000c, 20'h0_0001,
        20'h0_0000, 20'h1_0005, 20'h2_0000, 20'h5_000c, 20'h4_0003, 20'h0_0001, 20'h0_0000,
        20'h1_0006, 20'h2_0000, 20'h5_0003, 20'h0_0001, 20'h0_0000, 20'h1_0004};
    assign st = {osc, bias, tbo, wdf, buzz, src, third, com, low, flag, rate, tst};
    lcd_serial_command_decoder lcd_serial_command_decoder_inst (
        .i_clk(clk), .i_srst(srst), .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n),
        .i_data(din), .o_data(dout), .o_data_oe(doe), .o_oscillator_on(osc),
        .o_bias_gen_on(bias), .o_timebase_out_on(tbo), .o_watchdog_flag_on(wdf),
        .o_buzzer_drive_on(buzz), .o_timebase_clear(tbc), .o_watchdog_clear(wdc),
        .o_clock_source(src), .o_bias_third(third), .o_commons(com),
        .o_buzzer_low_pitch(low), .o_flag_pin_on(flag), .o_rate_code(rate),
        .o_test_mode(tst), .o_ram_nibble_dbg(dbg));
    lcd_host_model host (.i_clk(clk), .i_dev_data(dout), .i_dev_oe(doe), .o_cs_n(cs_n),
        .o_wr_n(wr_n), .o_rd_n(rd_n), .o_data(din));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic wrap_up();
        if (bad_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    always @(posedge clk)
    begin
        ntb <= ntb + {7'h00, tbc === 1'b1};
        nwd <= nwd + {7'h00, wdc === 1'b1};
        cyc++;
        if (cyc == 50000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        host.tick(4);
        chk("reset", 16'h048e, st);
        foreach (link[i])
        begin
            case (link[i][19:16])
                4'h0: host.sel(link[i][0]);
                4'h1: host.id(link[i][2:0]);
                4'h2: host.addr(link[i][5:0]);
                4'h3: host.cmd(link[i][8:0]);
                4'h4: host.nib(link[i][3:0]);
                4'h5:
                begin
                    host.rnib(n);
                    chk("nibble", link[i][15:0], {12'h000, n});
                    chk("fetched", link[i][15:0], {12'h000, dbg});
                end
                4'h6: chk("abort", link[i][15:0], st);
                default: chk("clears", link[i][15:0], {ntb, nwd});
            endcase
        end
        foreach (rows[i])
        begin
            host.cmd({rows[i][23:16], 1'b0});
            chk("state", rows[i][15:0], st);
        end
        host.sel(1'b1);
        srst <= 1'b1;
        host.tick(2);
        srst <= 1'b0;
        host.tick(4);
        chk("reset2", 16'h048e, st);
        wrap_up();
    end
endmodule
